// >>> design/pmcc_pkg.sv
// Purpose: Constants for the power mode and clock control block
// Assumes: 100 MHz bus clock; registers reached over AHB-Lite
// Notes: Offsets are byte addresses of aligned 32-bit words
// Functional notes
// - Sleep halts only the processor, keeps peripherals running and wakes on any interrupt or event.
// - Stop gates the core domain clocks and disables the PLL and both oscillators while keeping SRAM and registers.
// - During stop the regulator may be set to normal or low-power state.
// - Stop is left on any of the 16 external event lines or the other wake sources.
// - Standby switches off the regulator, the core domain and all oscillators; only backup state is kept.
// - Standby is left on reset pin, watchdog reset, wake pin rising edge or RTC alarm.
// - RTC, independent watchdog and their clocks keep running in stop and standby.
// - After reset the internal RC oscillator clocks the processor until software picks another source.
// - A selected external clock is monitored; on failure the system falls back to the RC oscillator and may interrupt.
// - Flash wait states are zero up to 24 MHz, one up to 48 MHz and two above.
package pmcc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CLK = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_FREQ = 8'h0c;
	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LPREG_BIT = 2;
	localparam int CTRL_ENTER_BIT = 3;
	localparam int CLK_SEL_LSB = 0;
	localparam int CLK_FIE_BIT = 2;
	localparam int CLK_MON_BIT = 3;
	localparam int STAT_FAIL_BIT = 8;
	// Reset values
	localparam logic [7:0] FREQ_RST = 8'h08;
	localparam logic [1:0] SEL_RST = 2'h0;
	// Frequency thresholds in MHz
	localparam logic [7:0] WS1_MHZ = 8'h18;
	localparam logic [7:0] WS2_MHZ = 8'h30;
	localparam logic [7:0] BUS_MAX_MHZ = 8'h48;
	localparam logic [7:0] SLOW_MAX_MHZ = 8'h24;
	// Clock failure: no edge seen within this window
	localparam int FAIL_NS = 1000;
	localparam int CLK_NS = 10;
	localparam logic [7:0] FAIL_CYC = 8'((FAIL_NS / CLK_NS));
	localparam int EXT_LINES = 16;
	// Power modes
	typedef enum logic [1:0] {
		PMCC_RUN = 2'b00,
		PMCC_SLEEP = 2'b01,
		PMCC_STOP = 2'b10,
		PMCC_STANDBY = 2'b11
	} pmcc_mode_type;
	// System clock sources
	typedef enum logic [1:0] {
		PMCC_SRC_RC = 2'b00,
		PMCC_SRC_XTAL = 2'b01,
		PMCC_SRC_PLL = 2'b10,
		PMCC_SRC_RSV = 2'b11
	} pmcc_src_type;
endpackage : pmcc_pkg

// >>> design/pmcc_clkmon.sv
// Purpose: Watch the external crystal oscillator for missing edges
// Assumes: Oscillator toggles far faster than the timeout window
// Notes: Output is a one-cycle failure pulse
`timescale 1ns/1ps
`default_nettype none
module pmcc_clkmon (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Monitor
	input wire logic i_enable,
	input wire logic i_osc,
	output logic o_fail
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [7:0] cnt;
		logic fail;
	} pmcc_mon_type;
	pmcc_mon_type st_r, st_nxt;
	// Synchronise the raw oscillator then count cycles since its last edge
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = i_osc;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.fail = 1'b0;
		if (!i_enable || (st_r.s2 != st_r.s3)) begin
			st_nxt.cnt = 8'h00;
		end else if (st_r.cnt == pmcc_pkg::FAIL_CYC) begin
			st_nxt.fail = 1'b1;
			st_nxt.cnt = 8'h00;
		end else begin
			st_nxt.cnt = st_r.cnt + 8'h01;
		end
	end
	// State register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_fail = st_r.fail;
endmodule : pmcc_clkmon
`default_nettype wire

// >>> design/pmcc_top.sv
// Purpose: Low-power mode sequencing, clock source selection, flash waits
// Assumes: Software at AHB-Lite; wake sources are asynchronous pins
// Notes: Mode entry is taken when the processor reports it is idle
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pmcc_top (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Processor and wake sources
	input wire logic i_cpu_idle,
	input wire logic i_irq_or_event,
	input wire logic [15:0] i_external_event_lines,
	input wire logic i_supply_voltage_monitor,
	input wire logic i_usb_wakeup,
	input wire logic i_rtc_alarm,
	input wire logic i_comparator_out,
	input wire logic i_serial_wakeup,
	input wire logic i_external_reset_pin_n,
	input wire logic i_independent_watchdog_rst,
	input wire logic i_wake_pin,
	input wire logic i_external_crystal_osc,
	// Power and clock controls
	output logic o_cpu_clk_en,
	output logic o_periph_clk_en,
	output logic o_core_clk_en,
	output logic o_pll_en,
	output logic o_internal_rc_osc_en,
	output logic o_external_crystal_osc_en,
	output logic o_regulator_on,
	output logic o_regulator_lowpower,
	output logic o_core_power_on,
	output logic o_rtc_wdg_clk_en,
	output logic [1:0] o_sysclk_sel,
	output logic [1:0] o_flash_wait,
	output logic o_standby_reset,
	output logic o_clk_fail_irq
);
	typedef struct packed {
		pmcc_pkg::pmcc_mode_type mode;
		pmcc_pkg::pmcc_mode_type req;
		logic lpreg;
		logic enter;
		pmcc_pkg::pmcc_src_type sel;
		logic fie;
		logic mon_en;
		logic fail;
		logic [7:0] freq;
		logic [1:0] wait_st;
		logic wake_q;
		logic dph_en;
		logic dph_wr;
		logic [7:0] dph_addr;
		logic [31:0] rdata;
		logic rd_wait;
		logic [21:0] sy1;
		logic [21:0] sy2;
		logic standby_rst;
	} pmcc_state_type;
	pmcc_state_type st_r, st_nxt;
	logic mon_fail;
	logic [21:0] raw_in;
	logic [15:0] ev;
	logic stop_wake;
	logic stby_wake;
	logic wake_rise;
	logic rd_hit;
	logic [31:0] rd_word;
	// Clock failure monitor runs whenever a source other than the RC oscillator is selected, outside stop and standby
	pmcc_clkmon u_mon (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		// Crystal is off in stop and standby, so its silence is no failure
		.i_enable(st_r.mon_en && !st_r.mode[1]),
		.i_osc(i_external_crystal_osc),
		.o_fail(mon_fail)
	);
	// All wake pins except i_irq_or_event pass two flip-flops before use
	assign raw_in = {i_external_event_lines, i_supply_voltage_monitor,
		i_usb_wakeup, i_rtc_alarm, i_comparator_out, i_serial_wakeup,
		i_wake_pin};
	assign ev = st_r.sy2[21:6];
	// Any external event line or peripheral wake source ends stop
	assign stop_wake = (|ev) || (|st_r.sy2[5:1]);
	assign wake_rise = st_r.sy2[0] && !st_r.wake_q;
	// Reset pin and watchdog reset go straight to the reset input here
	assign stby_wake = wake_rise || st_r.sy2[3];
	// Read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (st_r.dph_addr)
			pmcc_pkg::OFF_CTRL: begin
				rd_word = {28'h0000000, st_r.enter, st_r.lpreg, st_r.req};
			end
			pmcc_pkg::OFF_CLK: begin
				rd_word = {28'h0000000, st_r.mon_en, st_r.fie, st_r.sel};
			end
			pmcc_pkg::OFF_STAT: begin
				rd_word = {23'h000000, st_r.fail, 2'h0, st_r.wait_st,
					2'h0, st_r.mode};
			end
			pmcc_pkg::OFF_FREQ: begin
				rd_word = {24'h000000, st_r.freq};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end
	// Next-state logic: bus, clock source, mode sequencing
	always_comb begin
		st_nxt = st_r;
		st_nxt.sy1 = raw_in;
		st_nxt.sy2 = st_r.sy1;
		st_nxt.wake_q = st_r.sy2[0];
		st_nxt.standby_rst = 1'b0;
		// Data phase of a captured write
		if (st_r.dph_en && st_r.dph_wr) begin
			unique case (st_r.dph_addr)
				pmcc_pkg::OFF_CTRL: begin
					st_nxt.req = pmcc_pkg::pmcc_mode_type'(i_hwdata[1:0]);
					st_nxt.lpreg = i_hwdata[pmcc_pkg::CTRL_LPREG_BIT];
					st_nxt.enter = i_hwdata[pmcc_pkg::CTRL_ENTER_BIT];
				end
				pmcc_pkg::OFF_CLK: begin
					st_nxt.sel = pmcc_pkg::pmcc_src_type'(i_hwdata[1:0]);
					st_nxt.fie = i_hwdata[pmcc_pkg::CLK_FIE_BIT];
				end
				pmcc_pkg::OFF_STAT: begin
					// Write one clears the failure flag
					if (i_hwdata[pmcc_pkg::STAT_FAIL_BIT]) begin
						st_nxt.fail = 1'b0;
					end
				end
				pmcc_pkg::OFF_FREQ: begin
					st_nxt.freq = i_hwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		// A read waits one cycle so hrdata stands from a flip-flop at the
		// ready edge and already sees a write completed just before it
		if (st_r.dph_en && !st_r.dph_wr && !st_r.rd_wait) begin
			st_nxt.rdata = rd_hit ? rd_word : 32'h0000_0000;
			st_nxt.rd_wait = 1'b1;
		end else begin
			// Address phase capture; held while a read waits
			st_nxt.rd_wait = 1'b0;
			st_nxt.dph_en = i_hsel && i_hready && i_htrans[1];
			st_nxt.dph_wr = i_hwrite;
			st_nxt.dph_addr = i_haddr[7:0];
		end
		// Monitor only while an external source drives the system
		st_nxt.mon_en = (st_nxt.sel != pmcc_pkg::PMCC_SRC_RC);
		if (mon_fail) begin
			st_nxt.sel = pmcc_pkg::PMCC_SRC_RC;
			st_nxt.mon_en = 1'b0;
			st_nxt.fail = 1'b1; // Set beats a same-cycle clear
		end
		// Flash wait states follow the programmed processor clock
		if (st_nxt.sel == pmcc_pkg::PMCC_SRC_RC) begin
			st_nxt.freq = pmcc_pkg::FREQ_RST;
		end
		if (st_nxt.freq > pmcc_pkg::WS2_MHZ) begin
			st_nxt.wait_st = 2'h2;
		end else if (st_nxt.freq > pmcc_pkg::WS1_MHZ) begin
			st_nxt.wait_st = 2'h1;
		end else begin
			st_nxt.wait_st = 2'h0;
		end
		// Mode sequencing
		unique case (st_r.mode)
			pmcc_pkg::PMCC_RUN: begin
				if (st_r.enter && i_cpu_idle &&
					st_r.req != pmcc_pkg::PMCC_RUN) begin
					st_nxt.mode = st_r.req;
					st_nxt.enter = 1'b0;
				end
			end
			pmcc_pkg::PMCC_SLEEP: begin
				if (i_irq_or_event || stop_wake) begin
					st_nxt.mode = pmcc_pkg::PMCC_RUN;
				end
			end
			pmcc_pkg::PMCC_STOP: begin
				if (stop_wake) begin
					st_nxt.mode = pmcc_pkg::PMCC_RUN;
					st_nxt.sel = pmcc_pkg::PMCC_SRC_RC;
					st_nxt.mon_en = 1'b0;
					st_nxt.freq = pmcc_pkg::FREQ_RST;
					st_nxt.wait_st = 2'h0;
				end
			end
			pmcc_pkg::PMCC_STANDBY: begin
				if (stby_wake) begin
					// Leaving standby is a full reset of the core
					st_nxt = '0;
					st_nxt.freq = pmcc_pkg::FREQ_RST;
					st_nxt.sy1 = raw_in;
					st_nxt.sy2 = st_r.sy1;
					st_nxt.wake_q = st_r.sy2[0];
					st_nxt.standby_rst = 1'b1;
				end
			end
		endcase
	end
	// State register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
			st_r.freq <= pmcc_pkg::FREQ_RST;
			st_r.sel <= pmcc_pkg::PMCC_SRC_RC;
		end else begin
			st_r <= st_nxt;
		end
	end
	// Reads insert one wait state; writes and idle answer at once, OKAY
	assign o_hreadyout = !(st_r.dph_en && !st_r.dph_wr && !st_r.rd_wait);
	assign o_hresp = 1'b0;
	assign o_hrdata = st_r.rdata;
	// Power and clock gating by mode
	assign o_cpu_clk_en = (st_r.mode == pmcc_pkg::PMCC_RUN);
	assign o_periph_clk_en = !st_r.mode[1];
	assign o_core_clk_en = !st_r.mode[1];
	assign o_pll_en = !st_r.mode[1] &&
		(st_r.sel == pmcc_pkg::PMCC_SRC_PLL);
	assign o_internal_rc_osc_en = !st_r.mode[1];
	assign o_external_crystal_osc_en = !st_r.mode[1] &&
		(st_r.sel != pmcc_pkg::PMCC_SRC_RC);
	assign o_regulator_on = (st_r.mode != pmcc_pkg::PMCC_STANDBY);
	assign o_regulator_lowpower = (st_r.mode == pmcc_pkg::PMCC_STOP) &&
		st_r.lpreg;
	assign o_core_power_on = (st_r.mode != pmcc_pkg::PMCC_STANDBY);
	assign o_rtc_wdg_clk_en = 1'b1;
	assign o_sysclk_sel = st_r.sel;
	assign o_flash_wait = st_r.wait_st;
	assign o_standby_reset = st_r.standby_rst;
	assign o_clk_fail_irq = st_r.fail && st_r.fie;
	// Bus limits stay software's job; unused pins kept for wiring
	logic unused_ok;
	assign unused_ok = &{1'b0, i_hsize, i_haddr[31:8],
		i_external_reset_pin_n, i_independent_watchdog_rst};
endmodule : pmcc_top
`default_nettype wire

// >>> testbench/pmcc_assertions.sv
// Purpose: Output checks for pmcc_top
// Assumes: Bound into pmcc_top
// Notes: Mode is inferred from the enable outputs
`timescale 1ns/1ps
`default_nettype none
module pmcc_chk (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Wake inputs
	input wire logic [15:0] i_external_event_lines,
	input wire logic i_wake_pin,
	// Controls
	input wire logic o_cpu_clk_en,
	input wire logic o_periph_clk_en,
	input wire logic o_core_clk_en,
	input wire logic o_pll_en,
	input wire logic o_internal_rc_osc_en,
	input wire logic o_external_crystal_osc_en,
	input wire logic o_regulator_on,
	input wire logic o_regulator_lowpower,
	input wire logic o_core_power_on,
	input wire logic o_rtc_wdg_clk_en,
	input wire logic [1:0] o_sysclk_sel,
	input wire logic [1:0] o_flash_wait,
	input wire logic o_standby_reset,
	input wire logic o_clk_fail_irq
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// Mode relations between enables
	property p_sleep;
		!o_cpu_clk_en && o_internal_rc_osc_en |-> o_periph_clk_en;
	endproperty
	property p_stop;
		!o_core_clk_en && o_core_power_on |-> !o_pll_en
			&& !o_internal_rc_osc_en && !o_external_crystal_osc_en;
	endproperty
	property p_lp;
		o_regulator_lowpower |-> !o_core_clk_en && o_core_power_on;
	endproperty
	property p_stby;
		!o_core_power_on |-> !o_regulator_on && !o_internal_rc_osc_en;
	endproperty
	property p_rtc;
		o_rtc_wdg_clk_en;
	endproperty
	property p_fail;
		o_clk_fail_irq |-> o_sysclk_sel == 2'h0 && !o_pll_en;
	endproperty
	property p_ws;
		o_flash_wait != 2'h3;
	endproperty
	// Wake latency is bounded to allow for the input synchronisers
	property p_wake;
		$rose(|i_external_event_lines) && !o_core_clk_en
			&& o_core_power_on |-> ##[1:8] o_core_clk_en;
	endproperty
	property p_pin;
		$rose(i_wake_pin) && !o_core_power_on |-> ##[1:8] o_standby_reset;
	endproperty
	property p_rc;
		$rose(o_core_clk_en) |-> o_sysclk_sel == 2'h0;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep");
	a_stop: assert property (p_stop) else $error("stop");
	a_lp: assert property (p_lp) else $error("lowpower");
	a_stby: assert property (p_stby) else $error("standby");
	a_rtc: assert property (p_rtc) else $error("rtc clock");
	a_fail: assert property (p_fail) else $error("fallback");
	a_ws: assert property (p_ws) else $error("waits");
	a_wake: assert property (p_wake) else $error("stop wake");
	a_pin: assert property (p_pin) else $error("pin wake");
	a_rc: assert property (p_rc) else $error("wake source");
	// Main scenarios reached
	c_sleep: cover property (!o_cpu_clk_en && o_core_clk_en);
	c_lp: cover property (o_regulator_lowpower);
	c_stby: cover property (o_standby_reset);
	c_fail: cover property (o_clk_fail_irq);
endmodule : pmcc_chk
`default_nettype wire

// >>> testbench/pmcc_top_bench.sv
// Purpose: Directed bench for pmcc_top
// Assumes: Bench acts as bus master, oscillator and wake sources
// Notes: Oscillator stops on request to provoke a failure
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("wrong value %s exp %0h got %0h", n, e, g); \
	end \
end
module pmcc_top_bench;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_hsel = 1'b1;
	logic [31:0] i_haddr = 32'h0;
	logic [1:0] i_htrans = 2'h0;
	logic i_hwrite = 1'b0;
	logic [2:0] i_hsize = 3'h2;
	logic [31:0] i_hwdata = 32'h0;
	logic i_hready;
	logic i_cpu_idle = 1'b0;
	logic i_irq_or_event = 1'b0;
	logic [15:0] i_external_event_lines;
	logic i_supply_voltage_monitor, i_usb_wakeup, i_rtc_alarm;
	logic i_comparator_out, i_serial_wakeup;
	logic i_external_reset_pin_n = 1'b1;
	logic i_independent_watchdog_rst = 1'b0;
	logic i_wake_pin = 1'b0;
	logic i_external_crystal_osc = 1'b0;
	logic [31:0] o_hrdata;
	logic o_hreadyout, o_hresp, o_cpu_clk_en, o_periph_clk_en;
	logic o_core_clk_en, o_pll_en, o_internal_rc_osc_en;
	logic o_external_crystal_osc_en, o_regulator_on, o_regulator_lowpower;
	logic o_core_power_on, o_rtc_wdg_clk_en, o_standby_reset;
	logic o_clk_fail_irq;
	logic [1:0] o_sysclk_sel, o_flash_wait;
	logic [6:0] src = 7'h0;
	logic osc_run = 1'b0;
	logic [31:0] rdv;
	// Processor clocks stay within the 72 MHz bus limit
	logic [7:0] fr [5] = '{8'h18, 8'h19, 8'h30, 8'h31, 8'h48};
	logic [1:0] ws [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	int failures = 0;
	int cmp_count = 0;
	int k;
	int n;
	// Single slave, so its ready is the bus ready
	assign i_hready = o_hreadyout;
	assign i_external_event_lines = {src[1], 14'h0, src[0]};
	assign i_supply_voltage_monitor = src[2];
	assign i_usb_wakeup = src[3];
	assign i_rtc_alarm = src[4];
	assign i_comparator_out = src[5];
	assign i_serial_wakeup = src[6];
	pmcc_top u_pmcc_top (.*);
	// Clock and running crystal
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		// Crystal only swings while the design powers it
		if (osc_run && o_external_crystal_osc_en)
			i_external_crystal_osc <= ~i_external_crystal_osc;
	end
	// One single transfer; read data taken at the data phase ready edge,
	// then one idle edge so the effects of a write are visible
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		i_haddr <= {24'h0, a};
		i_hwrite <= w;
		i_htrans <= 2'h2;
		do @(posedge i_clock); while (!i_hready);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_clock); while (!i_hready);
		q = o_hrdata;
		@(posedge i_clock);
	endtask : bus
	task final_report;
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	// Watchdog far beyond the expected few hundred cycles
	initial begin
		#200000;
		failures++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		`CHK("sel", 2'h0, o_sysclk_sel)
		bus(0, 8'h0c, 0, rdv);
		`CHK("freq", 32'h8, rdv)
		`CHK("resp", 1'b0, o_hresp)
		bus(1, 8'h10, 32'hff, rdv);
		bus(0, 8'h10, 0, rdv);
		`CHK("unmapped", 32'h0, rdv)
		// Wait states at both boundaries
		osc_run <= 1'b1;
		bus(1, 8'h04, 32'h1, rdv);
		for (k = 0; k < 5; k++) begin
			bus(1, 8'h0c, {24'h0, fr[k]}, rdv);
			bus(0, 8'h08, 0, rdv);
			`CHK("wait", ws[k], o_flash_wait)
			`CHK("stat", ws[k], rdv[5:4])
		end
		// Crystal stops with the interrupt enabled
		bus(1, 8'h04, 32'h5, rdv);
		osc_run <= 1'b0;
		for (n = 0; n < 300 && !o_clk_fail_irq; n++) @(posedge i_clock);
		`CHK("gap", 1'b1, n >= 90)
		`CHK("irq", 1'b1, o_clk_fail_irq)
		`CHK("sel", 2'h0, o_sysclk_sel)
		bus(0, 8'h0c, 0, rdv);
		`CHK("freq", 32'h8, rdv)
		bus(1, 8'h08, 32'h100, rdv);
		`CHK("irq", 1'b0, o_clk_fail_irq)
		// Sleep, woken by an interrupt
		i_cpu_idle <= 1'b1;
		bus(1, 8'h00, 32'h9, rdv);
		for (n = 0; n < 20 && o_cpu_clk_en; n++) @(posedge i_clock);
		bus(0, 8'h08, 0, rdv);
		`CHK("mode", 2'h1, rdv[1:0])
		`CHK("cpu", 1'b0, o_cpu_clk_en)
		`CHK("periph", 1'b1, o_periph_clk_en)
		i_irq_or_event <= 1'b1;
		for (n = 0; n < 20 && !o_cpu_clk_en; n++) @(posedge i_clock);
		i_irq_or_event <= 1'b0;
		`CHK("cpu", 1'b1, o_cpu_clk_en)
		// Stop, woken by event lines 0 and 15 and each peripheral source in turn
		osc_run <= 1'b1;
		for (k = 0; k < 7; k++) begin
			bus(1, 8'h04, {30'h0, k[1], !k[1]}, rdv);
			`CHK("pll", k[1], o_pll_en)
			bus(1, 8'h00, {28'h0, 1'b1, k[0], 2'h2}, rdv);
			for (n = 0; n < 20 && o_core_clk_en; n++) @(posedge i_clock);
			`CHK("core", 1'b0, o_core_clk_en)
			`CHK("xtal", 1'b0, o_external_crystal_osc_en)
			`CHK("pll", 1'b0, o_pll_en)
			`CHK("rc", 1'b0, o_internal_rc_osc_en)
			`CHK("lp", k[0], o_regulator_lowpower)
			`CHK("rtc", 1'b1, o_rtc_wdg_clk_en)
			src <= 7'h1 << k;
			for (n = 0; n < 20 && !o_core_clk_en; n++) @(posedge i_clock);
			src <= 7'h0;
			`CHK("core", 1'b1, o_core_clk_en)
			`CHK("sel", 2'h0, o_sysclk_sel)
		end
		// Standby, left by the wake pin and by the alarm
		for (k = 0; k < 2; k++) begin
			bus(1, 8'h00, 32'hb, rdv);
			for (n = 0; n < 20 && o_core_power_on; n++) @(posedge i_clock);
			`CHK("pwr", 1'b0, o_core_power_on)
			`CHK("reg", 1'b0, o_regulator_on)
			`CHK("rtc", 1'b1, o_rtc_wdg_clk_en)
			if (k == 1)
				src <= 7'h10;
			else
				i_wake_pin <= 1'b1;
			for (n = 0; n < 20 && !o_standby_reset; n++) @(posedge i_clock);
			`CHK("wake", 1'b1, o_standby_reset)
			src <= 7'h0;
			i_wake_pin <= 1'b0;
			for (n = 0; n < 20 && !o_core_power_on; n++) @(posedge i_clock);
			`CHK("pwr", 1'b1, o_core_power_on)
		end
		final_report();
	end
endmodule : pmcc_top_bench
bind pmcc_top pmcc_chk u_pmcc_chk (.*);
`default_nettype wire
